// ---- logic/swg_pkg.sv ----
// Purpose: constants and carriers for the sleep wake and gate drive block
// Assumes: 40 MHz system clock
// Notes: timing counts derived from printed times
package swg_pkg;
  // -----------------------------------------
  // timing
  // -----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BLANK_MS = 50;
  localparam int unsigned BLANK_CYC = CLK_HZ / 1000 * BLANK_MS;
  localparam int unsigned SINK_US = 300;
  localparam int unsigned SINK_CYC = CLK_HZ / 1_000_000 * SINK_US;
  localparam int unsigned PUMP_HZ = 32_000;
  // half period, rounded down for 50% duty
  localparam int unsigned PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);
  localparam int unsigned NUM_GATES = 3;
  localparam int unsigned GATE_DSG = 0;
  localparam int unsigned GATE_CHG = 1;
  localparam int unsigned GATE_PCHG = 2;

  // -----------------------------------------
  // types
  // -----------------------------------------
  typedef enum logic [1:0] {
    SWG_NORMAL = 2'b00,
    SWG_BLANK = 2'b01,
    SWG_ARMED = 2'b10,
    SWG_POWERDOWN = 2'b11
  } swg_mode_e;

  typedef struct packed {
    logic load;
    logic charger;
  } swg_detect_s;

  typedef struct packed {
    logic pump;
    logic sink;
    logic oe_n;
  } swg_gate_s;
endpackage : swg_pkg

// ---- logic/swg_top.sv ----
// Purpose: sleep wake qualification and power switch gate sequencing
// Assumes: detector inputs are asynchronous comparator levels
// Notes: gate outputs are drive, sink and active-low enable per switch
//
// Summary of operation
// - load detection wakes from sleep
// - powerdown wakes only on charger
// - sleep from voltage, timer or command
// - detectors blanked about 50 ms on entry
// - after blanking, any detection wakes device
// - no detection keeps detectors armed, asleep
// - charger on load monitor also wakes
// - switched-on gate connects to charge pump
// - turn-on drive pulsed 32 kHz, 50%
// - charge gates sink 300 us then float
// - discharge gate sinks 300 us then floats
// - host control makes discharge follow host bit
// - charger plus load wakes from powerdown with switches off
`timescale 1ns/10ps
`default_nettype none
module swg_top
  import swg_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = BLANK_CYC,
  parameter int unsigned SINK_CYCLES = SINK_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic load_monitor_pin,
  input wire logic charger_monitor_pin,
  input wire logic charger_on_load_pin,
  input wire logic sleep_voltage_level,
  input wire logic inactivity_sleep_timer,
  input wire logic sleep_command,
  input wire logic powerdown_request,
  input wire logic host_switch_control,
  input wire logic host_discharge_on,
  input wire logic [NUM_GATES-1:0] auto_gate_on,
  output logic in_sleep,
  output logic detect_enable,
  output logic switches_held_off,
  output swg_gate_s discharge_gate_drive,
  output swg_gate_s charge_gate_drive,
  output swg_gate_s precharge_gate_drive
);

  // -----------------------------------------
  // input synchronisers
  // -----------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] next_sync1;
  logic [5:0] next_sync2;
  swg_detect_s det;
  logic chg_on_ld;
  logic sleep_req;
  logic pd_req;

  always_comb begin
    next_sync1 = {powerdown_request, sleep_voltage_level,
                  inactivity_sleep_timer, charger_on_load_pin,
                  charger_monitor_pin, load_monitor_pin};
    next_sync2 = sync1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else if (clk_en) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  assign det.load = sync2[0];
  assign det.charger = sync2[1];
  assign chg_on_ld = sync2[2];
  // command comes from same-clock logic, no sync
  assign sleep_req = sync2[3] | sync2[4] | sleep_command;
  assign pd_req = sync2[5];

  // -----------------------------------------
  // sleep and wake sequencer
  // -----------------------------------------
  swg_mode_e mode;
  swg_mode_e next_mode;
  logic [31:0] blank_cnt;
  logic [31:0] next_blank_cnt;
  logic hold_off;
  logic next_hold_off;
  logic wake;

  assign wake = det.load | det.charger | chg_on_ld;

  always_comb begin
    next_mode = mode;
    next_blank_cnt = blank_cnt;
    next_hold_off = hold_off;
    if (hold_off && !det.load) begin
      next_hold_off = 1'b0;
    end
    case (mode)
      SWG_NORMAL: begin
        if (pd_req) begin
          next_mode = SWG_POWERDOWN;
        end else if (sleep_req) begin
          next_mode = SWG_BLANK;
          next_blank_cnt = 32'h0000_0000;
        end
      end
      SWG_BLANK: begin
        // detectors masked, already asleep
        if (blank_cnt >= BLANK_CYCLES - 1) begin
          next_mode = SWG_ARMED;
        end else begin
          next_blank_cnt = blank_cnt + 32'h0000_0001;
        end
      end
      SWG_ARMED: begin
        if (pd_req) begin
          next_mode = SWG_POWERDOWN;
        end else if (wake) begin
          next_mode = SWG_NORMAL;
        end
        // otherwise stay armed
      end
      SWG_POWERDOWN: begin
        if (det.charger) begin
          next_mode = SWG_NORMAL;
          next_hold_off = det.load;
        end
      end
      default: begin
        next_mode = SWG_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode <= SWG_NORMAL;
      blank_cnt <= 32'h0000_0000;
      hold_off <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      blank_cnt <= next_blank_cnt;
      hold_off <= next_hold_off;
    end
  end

  // -----------------------------------------
  // charge pump clock
  // -----------------------------------------
  logic [15:0] pump_cnt;
  logic [15:0] next_pump_cnt;
  logic pump_phase;
  logic next_pump_phase;

  always_comb begin
    next_pump_cnt = pump_cnt + 16'h0001;
    next_pump_phase = pump_phase;
    if (pump_cnt >= 16'(PUMP_HALF_CYC - 1)) begin
      next_pump_cnt = 16'h0000;
      next_pump_phase = ~pump_phase;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pump_cnt <= 16'h0000;
      pump_phase <= 1'b0;
    end else if (clk_en) begin
      pump_cnt <= next_pump_cnt;
      pump_phase <= next_pump_phase;
    end
  end

  // -----------------------------------------
  // gate drivers
  // -----------------------------------------
  logic [NUM_GATES-1:0] want_on;
  logic [NUM_GATES-1:0] was_on;
  logic [NUM_GATES-1:0] next_was_on;
  logic [NUM_GATES-1:0][31:0] sink_cnt;
  logic [NUM_GATES-1:0][31:0] next_sink_cnt;
  swg_gate_s [NUM_GATES-1:0] gate;
  swg_gate_s [NUM_GATES-1:0] next_gate;
  logic asleep;

  assign asleep = (mode != SWG_NORMAL);

  always_comb begin
    want_on = auto_gate_on;
    if (host_switch_control) begin
      want_on[GATE_DSG] = host_discharge_on;
    end
    if (asleep || hold_off) begin
      want_on = '0;
    end
  end

  always_comb begin
    next_was_on = want_on;
    next_sink_cnt = sink_cnt;
    for (int i = 0; i < NUM_GATES; i++) begin
      next_gate[i] = '{pump: 1'b0, sink: 1'b0, oe_n: 1'b1};
      if (want_on[i]) begin
        // pumped drive while on; aborts any sink
        next_sink_cnt[i] = 32'h0000_0000;
        next_gate[i] = '{pump: pump_phase, sink: 1'b0, oe_n: 1'b0};
      end else if (was_on[i]) begin
        next_sink_cnt[i] = 32'(SINK_CYCLES);
        next_gate[i] = '{pump: 1'b0, sink: 1'b1, oe_n: 1'b0};
      end else if (sink_cnt[i] > 32'h0000_0001) begin
        next_sink_cnt[i] = sink_cnt[i] - 32'h0000_0001;
        next_gate[i] = '{pump: 1'b0, sink: 1'b1, oe_n: 1'b0};
      end else begin
        next_sink_cnt[i] = 32'h0000_0000; // float
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      was_on <= '0;
      sink_cnt <= '0;
      gate <= {NUM_GATES{3'b001}};
      in_sleep <= 1'b0;
      detect_enable <= 1'b0;
      switches_held_off <= 1'b0;
    end else if (clk_en) begin
      was_on <= next_was_on;
      sink_cnt <= next_sink_cnt;
      gate <= next_gate;
      in_sleep <= (next_mode == SWG_BLANK) || (next_mode == SWG_ARMED);
      detect_enable <= (next_mode == SWG_ARMED);
      switches_held_off <= next_hold_off;
    end
  end

  assign discharge_gate_drive = gate[GATE_DSG];
  assign charge_gate_drive = gate[GATE_CHG];
  assign precharge_gate_drive = gate[GATE_PCHG];

  // -----------------------------------------
  // checks
  // -----------------------------------------
  property p_blank_masks;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && mode == SWG_NORMAL && !pd_req && sleep_req)
      |=> (mode == SWG_BLANK) [*2];
  endproperty
  a_blank_masks: assert property (p_blank_masks)
    else $error("blanking not entered");

  property p_armed_wake;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && mode == SWG_ARMED && !pd_req && wake) |=> mode == SWG_NORMAL;
  endproperty
  a_armed_wake: assert property (p_armed_wake)
    else $error("armed detection did not wake");

  property p_armed_stay;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && mode == SWG_ARMED && !pd_req && !wake) |=> mode == SWG_ARMED;
  endproperty
  a_armed_stay: assert property (p_armed_stay)
    else $error("left sleep without detection");

  property p_pd_load;
    @(posedge clk_sys) disable iff (!rstn)
    (mode == SWG_POWERDOWN && !det.charger) |=> mode != SWG_NORMAL;
  endproperty
  a_pd_load: assert property (p_pd_load)
    else $error("powerdown woke without charger");

  property p_sleep_off;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && asleep) |=> !gate[GATE_DSG].pump && !gate[GATE_CHG].pump;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("gate driven while asleep");

  property p_sink_start;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && was_on[GATE_CHG] && !want_on[GATE_CHG])
      |=> gate[GATE_CHG].sink && !gate[GATE_CHG].oe_n;
  endproperty
  a_sink_start: assert property (p_sink_start)
    else $error("charge sink pulse missing");

  property p_dsg_sink;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && was_on[GATE_DSG] && !want_on[GATE_DSG])
      |=> gate[GATE_DSG].sink;
  endproperty
  a_dsg_sink: assert property (p_dsg_sink)
    else $error("discharge sink pulse missing");

  property p_host_dsg;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && host_switch_control && !asleep && !hold_off)
      |=> (was_on[GATE_DSG] == $past(host_discharge_on));
  endproperty
  a_host_dsg: assert property (p_host_dsg)
    else $error("discharge ignores host bit");

  property p_abort;
    @(posedge clk_sys) disable iff (!rstn)
    (clk_en && want_on[GATE_PCHG]) |=> !gate[GATE_PCHG].sink;
  endproperty
  a_abort: assert property (p_abort)
    else $error("sink not aborted on turn-on");

endmodule : swg_top
`default_nettype wire

// ---- dv/swg_pack_model.sv ----
// Purpose: pack side model: load, charger and host bits
// Assumes: bench requests change at the falling edge
// Notes: levels land one falling edge after the request
`timescale 1ns/10ps
`default_nettype none
module swg_pack_model (
  input wire logic clk_sys,
  input wire logic [4:0] want,
  output logic load_monitor_pin,
  output logic charger_monitor_pin,
  output logic charger_on_load_pin,
  output logic host_switch_control,
  output logic host_discharge_on
);
  // ----------
  // drive
  // ----------
  logic [4:0] held_want = 5'h00;
  // taken at the rising edge so a falling-edge request never races the drive
  always @(posedge clk_sys) begin
    held_want <= want;
  end
  initial begin
    {load_monitor_pin, charger_monitor_pin, charger_on_load_pin} = 3'h0;
    {host_switch_control, host_discharge_on} = 2'h0;
  end
  // host owns the discharge bit while control is taken
  always @(negedge clk_sys) begin
    {load_monitor_pin, charger_monitor_pin, charger_on_load_pin} <=
      held_want[4:2];
    {host_switch_control, host_discharge_on} <= held_want[1:0];
  end
endmodule : swg_pack_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for swg_top
// Assumes: shortened blank and sink counts
// Notes: random gate patterns from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import swg_pkg::*;
  localparam int unsigned BLK = 50;
  localparam int unsigned SNK = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic sv = 1'b0, it = 1'b0, sc = 1'b0, pd = 1'b0;
  logic [4:0] want = 5'h0;
  logic [2:0] ag = 3'h0;
  logic ld_p, ch_p, col_p, hs_p, hd_p, in_sleep, det_en, held;
  swg_gate_s dsg, chg, pchg;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 72;
  int n;
  int r;
  // ----------
  // harness
  // ----------
  always #12.5 clk_sys = ~clk_sys;
  swg_pack_model pack (.clk_sys(clk_sys), .want(want),
    .load_monitor_pin(ld_p), .charger_monitor_pin(ch_p),
    .charger_on_load_pin(col_p), .host_switch_control(hs_p),
    .host_discharge_on(hd_p));
  swg_top #(.BLANK_CYCLES(BLK), .SINK_CYCLES(SNK)) dut (.clk_sys(clk_sys),
    .rstn(rstn), .clk_en(ce), .load_monitor_pin(ld_p),
    .charger_monitor_pin(ch_p), .charger_on_load_pin(col_p),
    .sleep_voltage_level(sv), .inactivity_sleep_timer(it),
    .sleep_command(sc), .powerdown_request(pd), .host_switch_control(hs_p),
    .host_discharge_on(hd_p), .auto_gate_on(ag), .in_sleep(in_sleep),
    .detect_enable(det_en), .switches_held_off(held),
    .discharge_gate_drive(dsg), .charge_gate_drive(chg),
    .precharge_gate_drive(pchg));
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : tick
  function automatic swg_gate_s gate(input int gi);
    case (gi)
      0: return dsg;
      1: return chg;
      default: return pchg;
    endcase
  endfunction : gate
  function automatic logic [1:0] oe_sink(input int gi);
    swg_gate_s g;
    g = gate(gi);
    return {g.oe_n, g.sink};
  endfunction : oe_sink
  // ----------
  // tests
  // ----------
  initial begin
    tick(20);
    rstn = 1'b1;
    tick(3);
    for (int k = 0; k < 3; k++) begin
      {sv, it, sc} = 3'b100 >> k;
      tick(3);
      {sv, it, sc} = 3'h0;
      tick(4);
      check("in_sleep", in_sleep, 1);
      want = 5'b10000 >> k;
      tick(5);
      want = 5'h0;
      for (n = 9; det_en !== 1'b1 && n < 200; n++) tick(1);
      check("blank", n >= BLK - 2 && n <= BLK + 4, 1);
      tick(10);
      check("armed", {in_sleep, det_en}, 2'b11);
      want = 5'b10000 >> k;
      tick(6);
      check("woken", in_sleep, 0);
      want = 5'h0;
      tick(4);
    end
    pd = 1'b1;
    tick(4);
    pd = 1'b0;
    want = 5'b10000;
    ag = 3'h7;
    tick(8);
    want = 5'h0;
    sc = 1'b1;
    tick(3);
    sc = 1'b0;
    tick(6);
    check("powerdown", {in_sleep, dsg.oe_n}, 2'b01);
    want = 5'b11000;
    ag = 3'h7;
    tick(8);
    check("held", {held, dsg.oe_n}, 2'b11);
    want = 5'h0;
    tick(8);
    check("release", {held, dsg.oe_n}, 2'b00);
    ag = 3'h0;
    tick(SNK + 5);
    for (int gi = 0; gi < 3; gi++) begin
      ag = 3'h1 << gi;
      tick(3);
      check("on", {gate(gi).oe_n, gate(gi).sink}, 2'b00);
      r = gate(gi).pump;
      for (n = 0; gate(gi).pump === r[0] && n < 700; n++) tick(1);
      r = gate(gi).pump;
      for (n = 0; gate(gi).pump === r[0] && n < 700; n++) tick(1);
      check("pump half", n, PUMP_HALF_CYC);
      r = gate(gi).pump;
      for (n = 0; gate(gi).pump === r[0] && n < 700; n++) tick(1);
      check("pump other half", n, PUMP_HALF_CYC);
      ag = 3'h0;
      tick(1);
      for (n = 0; gate(gi).sink === 1'b1 && n < 100; n++) tick(1);
      check("sink len", n, SNK);
      check("float", gate(gi).oe_n, 1);
      ag = 3'h1 << gi;
      tick(5);
      ag = 3'h0;
      tick(5);
      ag = 3'h1 << gi;
      tick(1);
      check("abort", {gate(gi).oe_n, gate(gi).sink}, 2'b00);
      ag = 3'h0;
      tick(SNK + 5);
    end
    ce = 1'b0;
    ag = 3'h7;
    tick(4);
    check("frozen", pchg.oe_n, 1);
    ce = 1'b1;
    tick(2);
    check("thawed", pchg.oe_n, 0);
    ag = 3'h0;
    tick(SNK + 5);
    want = 5'b00010;
    ag = 3'h1;
    tick(SNK + 8);
    check("host off", dsg.oe_n, 1);
    want = 5'b00011;
    ag = 3'h0;
    tick(4);
    check("host on", dsg.oe_n, 0);
    want = 5'h0;
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      ag = r[2:0];
      tick(SNK + 10 + r[7:4]);
      for (int gi = 0; gi < 3; gi++)
        check("steady", oe_sink(gi), {~ag[gi], 1'b0});
    end
    give_verdict();
  end
  // bound well above the sum of all waits above
  initial begin
    #(25 * 40000);
    bad_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
